// *** logic/sfsb_cfg.svh ***
`ifndef SFSB_CFG_SVH
`define SFSB_CFG_SVH

// Register offsets
`define SFSB_OFS_SUPPLY_MASK     8'h9D
`define SFSB_OFS_INPUT_MASK      8'h9E
`define SFSB_OFS_SUPPLY_STATUS   8'hDA
`define SFSB_OFS_INPUT_STATUS    8'hDB
`define SFSB_OFS_SUPPLY_LOG      8'hDC
`define SFSB_OFS_INPUT_LOG       8'hDD
`define SFSB_OFS_SEQ_LOW         8'hDE
`define SFSB_OFS_SEQ_HIGH        8'hDF

// Reset values and unmapped read value
`define SFSB_RST_BYTE            8'h00
`define SFSB_RST_SUPPLY_LOG      7'h00
`define SFSB_RST_INPUT_LOG       5'h00
`define SFSB_RST_SUPPLY_MASK     7'h00
`define SFSB_RST_INPUT_MASK      5'h00

// Field positions and widths
`define SFSB_SUMMARY_BIT         7
`define SFSB_WATCHDOG_BIT        4
`define SFSB_SUPPLY_W            7
`define SFSB_INPUT_W             5
`define SFSB_SEQ_W               9

// Serial port framing
`define SFSB_BITS_PER_BYTE       4'h8

`endif

// *** logic/sfsb_pkg.sv ***
`default_nettype none

package sfsb_pkg;

  // Serial port states, one-hot
  typedef enum logic [8:0] {
    SFSB_IDLE      = 9'h001,
    SFSB_ADDR      = 9'h002,
    SFSB_ADDR_ACK  = 9'h004,
    SFSB_CMD       = 9'h008,
    SFSB_CMD_ACK   = 9'h010,
    SFSB_WDATA     = 9'h020,
    SFSB_WDATA_ACK = 9'h040,
    SFSB_RDATA     = 9'h080,
    SFSB_RACK      = 9'h100
  } sfsb_state_t;

endpackage

`default_nettype wire

// *** logic/sfsb_bank.sv ***
// Functional notes
// - Supply detector status bits 0-6 show live detector fault outputs.
// - Input/watchdog status bit 4 shows watchdog timeout elapsed.
// - Input/watchdog status bits 0-3 show live general input levels.
// - Sequencing status low bits 0-7 show driven outputs one to eight.
// - Sequencing status high bit 0 shows output nine; rest zero.
// - Summary flag bit 7 sets on any unmasked change since last input log read.
// - Supply log bits 0-6 record supply detector status per input.
// - Input log bit 4 records watchdog output level at last log update.
// - Input log bits 0-3 record general input levels at last log update.
// - Supply mask bits 0-6 keep matching supply out of summary flag and log readback.
// - Input mask bits 0-4 keep inputs and watchdog out of summary flag and log readback.
// - Both logs and both masks reset to zero.
// - Once summary flag is set, both logs freeze until the input log is read.
// - Reading the input log clears the summary flag unless unmasked live inputs differ from the logs.
// - Masked log bits read as zero; summary flag is never masked.
`include "sfsb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfsb_bank #(
  // Arbitrary value, set per board
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  // Two-wire port
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_n,
  // Monitored functions
  input  wire logic [`SFSB_SUPPLY_W-1:0]  supply_detector,
  input  wire logic                       watchdog_detector,
  input  wire logic [3:0]                 general_input,
  input  wire logic [`SFSB_SEQ_W-1:0]     sequencing_output
);

  sfsb_pkg::sfsb_state_t state;
  sfsb_pkg::sfsb_state_t next_state;

  logic                        scl_prev;
  logic                        sda_prev;
  logic [3:0]                  bit_cnt;
  logic [7:0]                  rx_shift;
  logic [7:0]                  tx_shift;
  logic [7:0]                  pointer;
  logic                        read_dir;
  logic                        drive_low;

  logic [`SFSB_SUPPLY_W-1:0]   supply_fault_mask;
  logic [`SFSB_INPUT_W-1:0]    input_watchdog_fault_mask;
  logic [`SFSB_SUPPLY_W-1:0]   supply_log;
  logic [`SFSB_INPUT_W-1:0]    input_log;
  logic                        summary_fault_flag;

  // Bus edge events
  wire scl_rise   = scl_in & ~scl_prev;
  wire scl_fall   = ~scl_in & scl_prev;
  wire start_cond = scl_in & scl_prev & sda_prev & ~sda_in;
  wire stop_cond  = scl_in & scl_prev & ~sda_prev & sda_in;
  wire byte_done  = (bit_cnt == `SFSB_BITS_PER_BYTE);
  wire addr_match = (rx_shift[7:1] == DEV_ADDR);

  // Live input view of the fault plane
  wire [`SFSB_INPUT_W-1:0] input_live = {watchdog_detector, general_input};

  // Logs hold raw levels; masks act at compare and readback, so
  // unmasking a function never raises the summary flag by itself
  wire [`SFSB_SUPPLY_W-1:0] supply_diff =
    (supply_detector ^ supply_log) & ~supply_fault_mask;
  wire [`SFSB_INPUT_W-1:0]  input_diff =
    (input_live ^ input_log) & ~input_watchdog_fault_mask;
  wire change_seen = (|supply_diff) | (|input_diff);

  // Byte transfer handshake points
  wire load_first = state[2] & scl_fall & read_dir;
  wire load_next  = state[8] & scl_fall;
  // Eighth read bit ends on the fall that takes the counter from seven to eight
  wire tx_last    = state[7] & scl_fall & (bit_cnt == 4'h7);
  wire load_tx    = load_first | load_next;
  wire write_byte = state[5] & scl_fall & byte_done;
  wire log_read   = load_tx & (pointer == `SFSB_OFS_INPUT_LOG);

  // Logs track live values until frozen; an input log read re-arms them
  wire log_update = ~summary_fault_flag | log_read;

  // Read data selection
  wire [7:0] supply_status_byte =
    {1'b0, supply_detector};
  wire [7:0] input_status_byte =
    {3'b000, watchdog_detector, general_input};
  wire [7:0] seq_low_byte  = sequencing_output[7:0];
  wire [7:0] seq_high_byte =
    {7'h00, sequencing_output[8]};
  wire [7:0] supply_log_byte =
    {summary_fault_flag, supply_log & ~supply_fault_mask};
  wire [7:0] input_log_byte =
    {3'b000, input_log & ~input_watchdog_fault_mask};

  // Status reads take live inputs directly, no latching
  wire [7:0] read_byte =
    (pointer == `SFSB_OFS_SUPPLY_STATUS) ? supply_status_byte :
    (pointer == `SFSB_OFS_INPUT_STATUS)  ? input_status_byte  :
    (pointer == `SFSB_OFS_SEQ_LOW)       ? seq_low_byte       :
    (pointer == `SFSB_OFS_SEQ_HIGH)      ? seq_high_byte      :
    (pointer == `SFSB_OFS_SUPPLY_LOG)    ? supply_log_byte    :
    (pointer == `SFSB_OFS_INPUT_LOG)     ? input_log_byte     :
    (pointer == `SFSB_OFS_SUPPLY_MASK)   ? {1'b0, supply_fault_mask} :
    (pointer == `SFSB_OFS_INPUT_MASK)    ?
      {3'b000, input_watchdog_fault_mask} :
    `SFSB_RST_BYTE;

  // Open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;

  // Serial port sequencing
  always_comb begin
    next_state = state;
    case (state)
      sfsb_pkg::SFSB_IDLE: begin
        next_state = sfsb_pkg::SFSB_IDLE;
      end
      sfsb_pkg::SFSB_ADDR: begin
        if (scl_fall && byte_done) begin
          next_state = addr_match ? sfsb_pkg::SFSB_ADDR_ACK
                                  : sfsb_pkg::SFSB_IDLE;
        end
      end
      sfsb_pkg::SFSB_ADDR_ACK: begin
        if (scl_fall) begin
          next_state = read_dir ? sfsb_pkg::SFSB_RDATA
                                : sfsb_pkg::SFSB_CMD;
        end
      end
      sfsb_pkg::SFSB_CMD: begin
        if (scl_fall && byte_done) begin
          next_state = sfsb_pkg::SFSB_CMD_ACK;
        end
      end
      sfsb_pkg::SFSB_CMD_ACK: begin
        if (scl_fall) begin
          next_state = sfsb_pkg::SFSB_WDATA;
        end
      end
      sfsb_pkg::SFSB_WDATA: begin
        if (scl_fall && byte_done) begin
          next_state = sfsb_pkg::SFSB_WDATA_ACK;
        end
      end
      sfsb_pkg::SFSB_WDATA_ACK: begin
        if (scl_fall) begin
          next_state = sfsb_pkg::SFSB_WDATA;
        end
      end
      sfsb_pkg::SFSB_RDATA: begin
        if (tx_last) begin
          next_state = sfsb_pkg::SFSB_RACK;
        end
      end
      sfsb_pkg::SFSB_RACK: begin
        // Master not-acknowledge ends the read
        if (scl_rise && sda_in) begin
          next_state = sfsb_pkg::SFSB_IDLE;
        end else if (scl_fall) begin
          next_state = sfsb_pkg::SFSB_RDATA;
        end
      end
      default: begin
        next_state = sfsb_pkg::SFSB_IDLE;
      end
    endcase
    if (start_cond) begin
      next_state = sfsb_pkg::SFSB_ADDR;
    end else if (stop_cond) begin
      next_state = sfsb_pkg::SFSB_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= sfsb_pkg::SFSB_IDLE;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      state    <= next_state;
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bit_cnt  <= 4'h0;
      rx_shift <= `SFSB_RST_BYTE;
    end else if (start_cond || (scl_fall && byte_done)) begin
      bit_cnt  <= 4'h0;
    end else if ((state[1] | state[3] | state[5]) && scl_rise) begin
      bit_cnt  <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[6:0], sda_in};
    end else if (state[7] && scl_fall) begin
      bit_cnt  <= bit_cnt + 4'h1;
    end
  end

  // Direction and register pointer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_dir <= 1'b0;
      pointer  <= `SFSB_RST_BYTE;
    end else if (state[1] && scl_fall && byte_done) begin
      read_dir <= rx_shift[0];
    end else if (state[4] && scl_fall) begin
      pointer  <= rx_shift;
    end
  end

  // Transmit shifter; second byte onward re-reads the same register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_shift <= `SFSB_RST_BYTE;
    end else if (load_tx) begin
      tx_shift <= read_byte;
    end else if (state[7] && scl_fall) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // Pin drive: acks, then data bits
  always_ff @(posedge clock) begin
    if (sys_rst || start_cond || stop_cond) begin
      drive_low <= 1'b0;
    end else if (scl_fall && byte_done &&
                 ((state[1] && addr_match) || state[3] || state[5])) begin
      drive_low <= 1'b1;
    end else if (load_tx) begin
      drive_low <= ~read_byte[7];
    end else if (state[7] && scl_fall) begin
      // Release for the host acknowledge after the eighth bit
      drive_low <= (bit_cnt == 4'h7) ? 1'b0 : ~tx_shift[6];
    end else if ((state[2] || state[4] || state[6]) && scl_fall) begin
      drive_low <= 1'b0;
    end
  end

  // Mask registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supply_fault_mask         <= `SFSB_RST_SUPPLY_MASK;
      input_watchdog_fault_mask <= `SFSB_RST_INPUT_MASK;
    end else if (write_byte) begin
      if (pointer == `SFSB_OFS_SUPPLY_MASK) begin
        supply_fault_mask <= rx_shift[`SFSB_SUPPLY_W-1:0];
      end else if (pointer == `SFSB_OFS_INPUT_MASK) begin
        input_watchdog_fault_mask <= rx_shift[`SFSB_INPUT_W-1:0];
      end
    end
  end

  // Fault plane; a change in the clearing cycle keeps the flag set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supply_log         <= `SFSB_RST_SUPPLY_LOG;
      input_log          <= `SFSB_RST_INPUT_LOG;
      summary_fault_flag <= 1'b0;
    end else if (log_update) begin
      supply_log         <= supply_detector;
      input_log          <= input_live;
      summary_fault_flag <= change_seen;
    end
  end

endmodule // sfsb_bank

`default_nettype wire

// *** sim/sfsb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfsb_host (
  // Two-wire side
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // Lines idle high under pull-up, clock still outside frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Four clocks a phase, above the three the port needs
  task automatic bit_x(input logic b, output logic r);
    pull <= !b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    r = sda;
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic start_c;
    pull <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    pull <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic stop_c;
    pull <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    pull <= 1'b0;
    wt(4);
  endtask
  // Ninth bit always released: device ack, or host nack on reads
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                        output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, a);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] r, d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start_c();
    byte_x({dev, 1'b0}, q, a0);
    byte_x(r, q, a1);
    byte_x(d, q, a2);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] r,
                    output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2, a3;
    start_c();
    byte_x({dev, 1'b0}, x, a0);
    byte_x(r, x, a1);
    start_c();
    byte_x({dev, 1'b1}, x, a2);
    byte_x(8'hFF, q, a3);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask
endmodule // sfsb_host
`default_nettype wire

// *** sim/sfsb_bank_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfsb_bank_checker (
  // Clock, reset and port pins
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rst_idle_a: assert property ($past(sys_rst) |-> sda_oe_n)
    else $error("data line driven after reset");
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data output not low");
  drive_start_a: assert property (
    $fell(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("drive began outside clock low");
  drive_end_a: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("drive released with clock high");
  hold_high_a: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data changed while clock high");
  drive_len_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*3])
    else $error("drive shorter than three cycles");
  start_free_a: assert property (
    $fell(sda_in) && scl_in && $past(scl_in) |-> sda_oe_n)
    else $error("device drove across a start");
  change_time_a: assert property (
    $changed(sda_oe_n) |-> $past(scl_in, 1) || $past(scl_in, 2) ||
      $past(scl_in, 3))
    else $error("drive change not after clock fall");
endmodule // sfsb_bank_checker
bind sfsb_bank sfsb_bank_checker chk_i (.clock(clock), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
`default_nettype wire

// *** sim/test_sfsb_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sfsb_bank;
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary device address
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [6:0] sup = 7'h00;
  logic       wd = 1'b0;
  logic [3:0] gi = 4'h0;
  logic [8:0] seq = 9'h000;
  logic       scl, pull, sda_out, sda_oe_n;
  wire        sda;
  int         n_fail = 0, samples_checked = 0, cycles = 0;
  always #4 clock = ~clock;
  // Pull-up: released line reads high
  assign sda = !(pull || !sda_oe_n);
  sfsb_host host (.clock(clock), .sda(sda), .scl(scl), .pull(pull));
  sfsb_bank #(.DEV_ADDR(DEV)) dut (.clock(clock), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .supply_detector(sup), .watchdog_detector(wd), .general_input(gi),
    .sequencing_output(seq));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", w, e, g);
      n_fail++;
    end
  endtask
  task automatic rdc(input logic [7:0] r, e);
    logic [7:0] q;
    logic       ok;
    host.rd(DEV, r, q, ok);
    chk($sformatf("ack %h", r), 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", r), e, q);
  endtask
  task automatic wrc(input logic [6:0] dev, input logic [7:0] r, d,
                     input logic eok);
    logic ok;
    host.wr(dev, r, d, ok);
    chk($sformatf("wr ack %h", r), {7'h00, eok}, {7'h00, ok});
  endtask
  // Settle time lets the flag land before the next read
  task automatic set_in(input logic [6:0] s, input logic w,
                        input logic [3:0] g);
    @(posedge clock);
    sup <= s;
    wd <= w;
    gi <= g;
    repeat (3) @(posedge clock);
  endtask
  task automatic t_reset;
    logic [7:0] ofs [9];
    ofs = '{8'h9D, 8'h9E, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'h90};
    for (int i = 0; i < 9; i++) rdc(ofs[i], 8'h00);
  endtask
  task automatic t_live;
    seq <= 9'h1A5;
    set_in(7'h55, 1'b1, 4'hA);
    rdc(8'hDA, 8'h55);
    rdc(8'hDB, 8'h1A);
    rdc(8'hDE, 8'hA5);
    rdc(8'hDF, 8'h01);
    wrc(DEV, 8'hDA, 8'hFF, 1'b1);
    rdc(8'hDA, 8'h55);
    wrc(7'h15, 8'h9D, 8'hFF, 1'b0);
  endtask
  task automatic t_log;
    rdc(8'hDC, 8'hD5);
    rdc(8'hDD, 8'h1A);
    rdc(8'hDD, 8'h1A);
    rdc(8'hDC, 8'h55);
    set_in(7'h55, 1'b0, 4'hB);
    set_in(7'h54, 1'b0, 4'hB);
    rdc(8'hDC, 8'hD5);
    rdc(8'hDD, 8'h0B);
    rdc(8'hDC, 8'hD4);
    rdc(8'hDD, 8'h0B);
    rdc(8'hDC, 8'h54);
  endtask
  task automatic t_mask;
    wrc(DEV, 8'h9D, 8'hFF, 1'b1);
    wrc(DEV, 8'h9E, 8'hFF, 1'b1);
    rdc(8'h9D, 8'h7F);
    rdc(8'h9E, 8'h1F);
    set_in(7'h2F, 1'b1, 4'h4);
    rdc(8'hDC, 8'h00);
    rdc(8'hDD, 8'h00);
    wrc(DEV, 8'h9D, 8'h7E, 1'b1);
    rdc(8'hDC, 8'h01);
    set_in(7'h2E, 1'b0, 4'h9);
    rdc(8'hDC, 8'h80);
    rdc(8'hDD, 8'h00);
    rdc(8'hDC, 8'h00);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_live();
    t_log();
    t_mask();
    end_sim();
  end
endmodule // test_sfsb_bank
`default_nettype wire
